// ### rtl/dcf_pkg.sv
/*
  Shared constants and types of the dual-clock FIFO flag block: sizes, timing
  constants, register map, strap codes, mode and pin carriers.
  Assumes a single 125 MHz system clock that samples both FIFO clock pins.
*/
package dcf_pkg;

  // ----------------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int DEPTH = 256;
  localparam int REG_W = 16;
  localparam int CLK_NS = 8;
  localparam int FIRST_SKEW_NS = 5;
  localparam int SECOND_SKEW_NS = 7;
  localparam int FIRST_SKEW_RAW = (FIRST_SKEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SECOND_SKEW_RAW = (SECOND_SKEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIRST_SKEW_CYC = (FIRST_SKEW_RAW < 1) ? 1 : FIRST_SKEW_RAW;
  localparam int SECOND_SKEW_CYC = (SECOND_SKEW_RAW < 1) ? 1 : SECOND_SKEW_RAW;
  localparam int SYNC_STAGES = 3;
  localparam int DEF_EMPTY_OFS = 31;
  localparam int DEF_FULL_OFS = 31;

  // ----------------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------------
  localparam logic [1:0] REG_EMPTY_OFS = 2'h0;
  localparam logic [1:0] REG_FULL_OFS = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_LEVEL = 2'h3;

  // ----------------------------------------------------------------------
  // strap codes {first_load, read_expansion_in, write_expansion_in}
  // ----------------------------------------------------------------------
  localparam logic [2:0] STRAP_THRU_A = 3'h1;
  localparam logic [2:0] STRAP_THRU_B = 3'h5;
  localparam logic [2:0] STRAP_DBL_A = 3'h2;
  localparam logic [2:0] STRAP_DBL_B = 3'h6;
  localparam logic [2:0] STRAP_SYNC_A = 3'h4;
  localparam logic [2:0] STRAP_CHAIN_A = 3'h3;
  localparam logic [2:0] STRAP_CHAIN_B = 3'h7;

  typedef enum logic [1:0] {
    DCF_INIT = 2'b01,
    DCF_RUN = 2'b10
  } dcf_state_t;

  typedef struct packed {
    logic thru;
    logic dbl;
    logic sync_almost;
    logic half_en;
  } dcf_mode_t;

  typedef struct packed {
    logic [5:0] pad;
    dcf_mode_t mode;
    logic [5:0] flags;
  } dcf_status_t;

  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wen_n;
    logic ren_n;
    logic load_n;
    logic first_load;
    logic rexp_in;
    logic wexp_in;
    logic [DATA_W-1:0] data;
  } dcf_pins_t;

  localparam dcf_pins_t PINS_IDLE = '{wclk: 1'b0, rclk: 1'b0, wen_n: 1'b1,
    ren_n: 1'b1, load_n: 1'b1, first_load: 1'b0, rexp_in: 1'b0, wexp_in: 1'b0, data: '0};

endpackage : dcf_pkg

// ### rtl/dcf_sync.sv
/*
  Three-stage pin synchroniser; a bit changes once stages two and three agree.
  Assumes pins are asynchronous to clk and slower than half its rate.
*/
`timescale 1ns/1ps
module dcf_sync
  import dcf_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] stable
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;

  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      stable <= INIT;
    end
    else if (ce)
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      stable <= (agree & s3) | (~agree & stable);
    end
  end

endmodule : dcf_sync

// ### rtl/dcf_cross.sv
/*
  Pointer hand-over between the write-edge and read-edge sides.
  Assumes adv is a one-cycle edge event of the receiving side.
*/
`timescale 1ns/1ps
module dcf_cross
  import dcf_pkg::*;
#(
  parameter int PW = 10,
  parameter int SKEW_CYC = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [PW-1:0] src,
  input wire logic adv,
  input wire logic dbl,
  output logic [PW-1:0] seen,
  output logic [PW-1:0] seen_next
);

  // updates younger than the skew window are not yet visible at an edge
  logic [PW-1:0] pipe [SKEW_CYC];
  logic [PW-1:0] stage1;
  logic [PW-1:0] stage2;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SKEW_CYC; i++)
      begin
        pipe[i] <= '0;
      end
      stage1 <= '0;
      stage2 <= '0;
    end
    else if (ce)
    begin
      pipe[0] <= src;
      for (int i = 1; i < SKEW_CYC; i++)
      begin
        pipe[i] <= pipe[i-1];
      end
      if (adv)
      begin
        stage1 <= pipe[SKEW_CYC-1];
        stage2 <= stage1;
      end
    end
  end

  assign seen = dbl ? stage2 : stage1;
  assign seen_next = dbl ? stage1 : pipe[SKEW_CYC-1];

endmodule : dcf_cross

// ### rtl/dcf_flags.sv
/*
  Dual-clock FIFO with full/empty, almost and half-full flags and strap-chosen
  timing modes. Both FIFO clocks arrive as pins and are sampled on clk.
  Assumes FIFO clock rates well below clk / 4 and static strap pins.
*/
`timescale 1ns/1ps

module dcf_flags
  import dcf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH,
  parameter int EMPTY_OFS_P = DEF_EMPTY_OFS,
  parameter int FULL_OFS_P = DEF_FULL_OFS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic offset_load_n,
  input wire logic first_load_strap,
  input wire logic read_expansion_in,
  input wire logic write_expansion_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic full_flag_n,
  output logic input_ready_n,
  output logic empty_flag_n,
  output logic output_ready_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic half_full_n,
  input wire logic [1:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [REG_W-1:0] reg_rdata
);

  localparam int PW = $clog2(DEPTH_P) + 2;
  localparam int AW = PW - 1;
  localparam int OW = $clog2(DEPTH_P + 1);
  localparam logic [PW-1:0] DEPTH_PW = PW'(DEPTH_P);
  localparam logic [PW-1:0] HALF_PW = PW'(DEPTH_P / 2);
  localparam logic [OW-1:0] EMPTY_OFS_RST = OW'(EMPTY_OFS_P);
  localparam logic [OW-1:0] FULL_OFS_RST = OW'(FULL_OFS_P);
  // straps are valid only once the sync stages and the agree stage have filled
  localparam logic [2:0] INIT_LAST = 3'(SYNC_STAGES + 1);

  // ----------------------------------------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------------------------------------
  dcf_pins_t pins_raw;
  dcf_pins_t pins;
  logic wclk_q;
  logic rclk_q;
  logic w_edge;
  logic r_edge;

  assign pins_raw = '{wclk: write_clk, rclk: read_clk, wen_n: write_en_n,
    ren_n: read_en_n, load_n: offset_load_n, first_load: first_load_strap,
    rexp_in: read_expansion_in, wexp_in: write_expansion_in, data: data_in};

  dcf_sync #(
    .W($bits(dcf_pins_t)),
    .INIT(PINS_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(pins_raw),
    .stable(pins)
  );

  // ----------------------------------------------------------------------
  // mode capture after reset release
  // ----------------------------------------------------------------------
  dcf_state_t state;
  dcf_state_t next_state;
  dcf_mode_t mode;
  dcf_mode_t strap_mode;
  logic [2:0] init_cnt;
  logic [2:0] strap;
  logic running;

  assign strap = {pins.first_load, pins.rexp_in, pins.wexp_in};
  assign strap_mode.thru = (strap == STRAP_THRU_A) || (strap == STRAP_THRU_B);
  // double buffering codes, all else single
  assign strap_mode.dbl = (strap == STRAP_DBL_A) || (strap == STRAP_DBL_B);
  assign strap_mode.sync_almost = (strap == STRAP_SYNC_A) || (strap == STRAP_THRU_B)
    || (strap == STRAP_DBL_B);
  assign strap_mode.half_en = (strap != STRAP_CHAIN_A) && (strap != STRAP_CHAIN_B);
  assign running = (state == DCF_RUN);

  always_comb
  begin
    case (state)
      DCF_INIT: next_state = (init_cnt == INIT_LAST) ? DCF_RUN : DCF_INIT;
      DCF_RUN: next_state = DCF_RUN;
      default: next_state = DCF_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= DCF_INIT;
      init_cnt <= 3'h0;
      mode <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      if (state == DCF_INIT)
      begin
        init_cnt <= init_cnt + 3'h1;
        mode <= strap_mode;
      end
    end
  end

  assign w_edge = running & pins.wclk & ~wclk_q;
  assign r_edge = running & pins.rclk & ~rclk_q;

  // ----------------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem [2**AW];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW-1:0] fptr;
  logic [PW-1:0] next_wptr;
  logic [PW-1:0] next_rptr;
  logic [PW-1:0] next_fptr;
  logic [PW-1:0] rptr_w_seen;
  logic [PW-1:0] rptr_w_next;
  logic [PW-1:0] wptr_r_seen;
  logic [PW-1:0] wptr_r_next;
  logic [PW-1:0] wptr_ae_next;
  logic [PW-1:0] rptr_af_next;
  logic w_full;
  logic r_empty;
  logic out_valid;
  logic wr_take;
  logic rd_take;
  logic rd_fetch;
  logic [PW-1:0] cap;
  logic [PW-1:0] rptr_full_view;
  logic next_w_full;
  logic thru_avail;

  // rptr into the write side, first skew window
  dcf_cross #(
    .PW(PW),
    .SKEW_CYC(FIRST_SKEW_CYC)
  ) u_cross_full (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(rptr),
    .adv(w_edge),
    .dbl(mode.dbl),
    .seen(rptr_w_seen),
    .seen_next(rptr_w_next)
  );

  // wptr into the read side, first skew window
  dcf_cross #(
    .PW(PW),
    .SKEW_CYC(FIRST_SKEW_CYC)
  ) u_cross_empty (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(wptr),
    .adv(r_edge),
    .dbl(mode.dbl),
    .seen(wptr_r_seen),
    .seen_next(wptr_r_next)
  );

  dcf_cross #(
    .PW(PW),
    .SKEW_CYC(SECOND_SKEW_CYC)
  ) u_cross_ae (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(wptr),
    .adv(r_edge),
    .dbl(1'b0),
    .seen(),
    .seen_next(wptr_ae_next)
  );

  // second skew window for almost-full
  dcf_cross #(
    .PW(PW),
    .SKEW_CYC(SECOND_SKEW_CYC)
  ) u_cross_af (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(rptr),
    .adv(w_edge),
    .dbl(1'b0),
    .seen(),
    .seen_next(rptr_af_next)
  );

  // capacity counts the output register in fall-through
  assign cap = DEPTH_PW + PW'(mode.thru);
  // writes refused while full or during offset access
  assign wr_take = w_edge & ~pins.wen_n & pins.load_n & ~w_full;
  assign next_wptr = wptr + PW'(wr_take);
  // fall-through sees frees one write edge later
  assign rptr_full_view = mode.thru ? rptr_w_seen : rptr_w_next;
  assign next_w_full = (next_wptr - rptr_full_view) >= cap;

  // fall-through fetch waits for the registered view
  assign thru_avail = (fptr != wptr_r_seen);
  // reads refused while empty or no word ready
  assign rd_take = r_edge & ~pins.ren_n & pins.load_n & (mode.thru ? out_valid : ~r_empty);
  assign rd_fetch = mode.thru ? (r_edge & (~out_valid | rd_take) & thru_avail) : rd_take;
  assign next_rptr = rptr + PW'(rd_take);
  assign next_fptr = fptr + PW'(rd_fetch);

  always_ff @(posedge clk)
  begin
    if (ce && wr_take)
    begin
      mem[wptr[AW-1:0]] <= pins.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      wptr <= '0;
      rptr <= '0;
      fptr <= '0;
      w_full <= 1'b0;
      r_empty <= 1'b1;
      out_valid <= 1'b0;
      data_out <= '0;
    end
    else if (ce)
    begin
      wclk_q <= pins.wclk;
      rclk_q <= pins.rclk;
      wptr <= next_wptr;
      rptr <= next_rptr;
      fptr <= next_fptr;
      if (w_edge)
      begin
        w_full <= next_w_full;
      end
      // standard empty follows the freshly crossed pointer
      if (r_edge)
      begin
        r_empty <= (next_fptr == wptr_r_next);
        out_valid <= rd_fetch | (out_valid & ~rd_take);
      end
      if (rd_fetch)
      begin
        data_out <= mem[fptr[AW-1:0]];
      end
    end
  end

  assign full_flag_n = mode.thru | ~w_full;
  assign input_ready_n = mode.thru & w_full;
  assign empty_flag_n = mode.thru | ~r_empty;
  assign output_ready_n = ~mode.thru | ~out_valid;

  // ----------------------------------------------------------------------
  // almost and half flags
  // ----------------------------------------------------------------------
  logic [OW-1:0] empty_ofs;
  logic [OW-1:0] full_ofs;
  logic [PW-1:0] ae_thr;
  logic [PW-1:0] af_thr;
  logic [PW-1:0] dir_w;
  logic [PW-1:0] dir_r;
  logic ae_sync_low;
  logic af_sync_low;

  assign ae_thr = PW'(empty_ofs) + PW'(mode.thru);
  assign af_thr = cap - PW'(full_ofs);
  assign dir_w = next_wptr - rptr;
  assign dir_r = wptr - next_rptr;
  assign ae_sync_low = (wptr_ae_next - next_rptr) <= ae_thr;
  assign af_sync_low = (next_wptr - rptr_af_next) >= af_thr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      half_full_n <= 1'b1;
    end
    else if (ce)
    begin
      if (mode.sync_almost)
      begin
        if (r_edge)
        begin
          almost_empty_n <= ~ae_sync_low;
        end
        if (w_edge)
        begin
          almost_full_n <= ~af_sync_low;
        end
      end
      else
      begin
        // falls on read edge, rises on write edge
        if (r_edge && (dir_r <= ae_thr))
        begin
          almost_empty_n <= 1'b0;
        end
        else if (w_edge && (dir_w > ae_thr))
        begin
          almost_empty_n <= 1'b1;
        end
        // falls on write edge, rises on read edge
        if (w_edge && (dir_w >= af_thr))
        begin
          almost_full_n <= 1'b0;
        end
        else if (r_edge && (dir_r < af_thr))
        begin
          almost_full_n <= 1'b1;
        end
      end
      if (!mode.half_en)
      begin
        half_full_n <= 1'b1;
      end
      else if (w_edge && (dir_w > HALF_PW))
      begin
        half_full_n <= 1'b0;
      end
      else if (r_edge && (dir_r <= HALF_PW))
      begin
        half_full_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  dcf_status_t status;
  logic [REG_W-1:0] rd_sel;

  assign status = '{pad: '0, mode: mode, flags: {half_full_n, almost_full_n,
    almost_empty_n, out_valid, r_empty, w_full}};
  assign rd_sel = (reg_addr == REG_EMPTY_OFS) ? REG_W'(empty_ofs) :
                  (reg_addr == REG_FULL_OFS) ? REG_W'(full_ofs) :
                  (reg_addr == REG_STATUS) ? REG_W'(status) :
                  REG_W'(wptr - rptr);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      empty_ofs <= EMPTY_OFS_RST;
      full_ofs <= FULL_OFS_RST;
      reg_rdata <= '0;
    end
    else if (ce)
    begin
      if (reg_we && (reg_addr == REG_EMPTY_OFS))
      begin
        empty_ofs <= reg_wdata[OW-1:0];
      end
      if (reg_we && (reg_addr == REG_FULL_OFS))
      begin
        full_ofs <= reg_wdata[OW-1:0];
      end
      reg_rdata <= reg_re ? rd_sel : '0;
    end
  end

endmodule : dcf_flags

// ### testbench/dcf_flags_chk.sv
/*
  Concurrent checks on the flag and data pins of dcf_flags, bound into it.
  Assumes FIFO clock pins slower than clk / 10 and ce held high.
*/
`timescale 1ns/1ps
module dcf_flags_chk
  import dcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic full_flag_n,
  input wire logic input_ready_n,
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic half_full_n
);
  // ----------
  // pin edge ages
  // ----------
  // sync plus edge register moves the flags four cycles after the pin edge, so nine is the outer bound
  logic w_q, r_q;
  logic [3:0] w_age, r_age, up;
  wire ok = (up == 4'hf);
  wire [3:0] next_w_age = (write_clk && !w_q) ? 4'h0 : w_age + {3'h0, w_age != 4'hf};
  wire [3:0] next_r_age = (read_clk && !r_q) ? 4'h0 : r_age + {3'h0, r_age != 4'hf};
  wire [3:0] next_up = up + {3'h0, !ok};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_q <= 1'b0;
      r_q <= 1'b0;
      w_age <= 4'hf;
      r_age <= 4'hf;
      up <= 4'h0;
    end
    else
    begin
      w_q <= write_clk;
      r_q <= read_clk;
      w_age <= next_w_age;
      r_age <= next_r_age;
      up <= next_up;
    end
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------
  // properties
  // ----------
  reset_state_a:
    assert property ($rose(rst_n) |-> (full_flag_n && !empty_flag_n && !almost_empty_n
      && almost_full_n && half_full_n && output_ready_n && !input_ready_n) [*2])
    else $error("flags left reset state during init");
  std_pair_a:
    assert property (!full_flag_n || !empty_flag_n |-> !input_ready_n && output_ready_n)
    else $error("ready flags active beside standard flags");
  thru_pair_a:
    assert property (input_ready_n || !output_ready_n |-> full_flag_n && empty_flag_n)
    else $error("standard flags active beside ready flags");
  empty_edge_a:
    assert property (ok && $changed(empty_flag_n) |-> r_age < 4'h9)
    else $error("empty flag moved away from a read edge");
  full_edge_a:
    assert property (ok && $changed(full_flag_n) |-> w_age < 4'h9)
    else $error("full flag moved away from a write edge");
  ordy_edge_a:
    assert property (ok && $changed(output_ready_n) |-> r_age inside {[4'h1:4'h8]})
    else $error("output ready moved away from a read edge");
  irdy_edge_a:
    assert property (ok && $changed(input_ready_n) |-> w_age inside {[4'h1:4'h8]})
    else $error("input ready moved away from a write edge");
  aempty_fall_a:
    assert property (ok && $fell(almost_empty_n) |-> r_age < 4'h9)
    else $error("almost empty fell away from a read edge");
  afull_fall_a:
    assert property (ok && $fell(almost_full_n) |-> w_age < 4'h9)
    else $error("almost full fell away from a write edge");
  half_fall_a:
    assert property (ok && $fell(half_full_n) |-> w_age < 4'h9)
    else $error("half full fell away from a write edge");
  half_rise_a:
    assert property (ok && $rose(half_full_n) |-> r_age < 4'h9)
    else $error("half full rose away from a read edge");
  dout_edge_a:
    assert property (ok && $changed(data_out) |-> r_age < 4'h9)
    else $error("read data moved away from a read edge");
endmodule : dcf_flags_chk

bind dcf_flags dcf_flags_chk chk (
  .clk(clk), .rst_n(rst_n), .write_clk(write_clk), .read_clk(read_clk),
  .data_out(data_out), .full_flag_n(full_flag_n), .input_ready_n(input_ready_n),
  .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n),
  .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
  .half_full_n(half_full_n)
);

// ### testbench/dcf_link_model.sv
/*
  Producer and consumer at the FIFO pins: free-running pin clocks, enables
  set at each falling pin edge, words sent from send_q, reads logged in got_q.
  Assumes the bench fills send_q and stalls both sides around resets.
*/
`timescale 1ns/1ps
module dcf_link_model
  import dcf_pkg::*;
(
  input wire logic thru,
  input wire logic stall_w,
  input wire logic stall_r,
  input wire logic full_flag_n,
  input wire logic input_ready_n,
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic [DATA_W-1:0] data_out,
  output logic write_clk,
  output logic read_clk,
  output logic write_en_n,
  output logic read_en_n,
  output logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] send_q[$];
  logic [DATA_W-1:0] got_q[$];
  int n_wr = 0;
  logic took = 1'b0;
  logic go_w;
  logic go_r;
  initial
  begin
    write_clk = 1'b0;
    write_en_n = 1'b1;
    data_in = '0;
    forever #64 write_clk = ~write_clk;
  end
  initial
  begin
    read_clk = 1'b0;
    read_en_n = 1'b1;
    #13;
    forever #76 read_clk = ~read_clk;
  end
  always @(negedge write_clk)
  begin
    if (!write_en_n)
    begin
      void'(send_q.pop_front());
      n_wr++;
    end
    go_w = !stall_w && send_q.size() > 0 && (thru ? !input_ready_n : full_flag_n);
    write_en_n <= !go_w;
    data_in <= go_w ? send_q[0] : ~data_in;
  end
  // read only with data; standard words land after the read edge
  always @(negedge read_clk)
  begin
    if (took && !thru)
      got_q.push_back(data_out);
    go_r = !stall_r && (thru ? !output_ready_n : empty_flag_n);
    if (go_r && thru)
      got_q.push_back(data_out);
    took = go_r;
    read_en_n <= !go_r;
  end
endmodule : dcf_link_model

// ### testbench/dcf_flags_tb.sv
/*
  Bench of dcf_flags: strap decode for every code, then for codes 0 to 5 almost-flag
  boundaries, fill to full, drain to empty and data order.
  Assumes the link model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module dcf_flags_tb
  import dcf_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic thru = 1'b0, stall_w = 1'b1, stall_r = 1'b1, reg_we = 1'b0, reg_re = 1'b0, ce = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [REG_W-1:0] reg_wdata = '0, v;
  wire [REG_W-1:0] reg_rdata;
  wire write_clk, read_clk, write_en_n, read_en_n, full_flag_n, input_ready_n;
  wire empty_flag_n, output_ready_n, almost_empty_n, almost_full_n, half_full_n;
  wire [DATA_W-1:0] data_in, data_out;
  logic [31:0] seed = 32'h842ea37f;
  logic [DATA_W-1:0] exp_q[$];
  dcf_mode_t md;
  int n_errors = 0, checked = 0, cyc = 0, cap, n, m, wbase;
  dcf_flags uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .write_clk(write_clk), .read_clk(read_clk),
    .write_en_n(write_en_n), .read_en_n(read_en_n), .offset_load_n(1'b1),
    .first_load_strap(strap[2]), .read_expansion_in(strap[1]),
    .write_expansion_in(strap[0]), .data_in(data_in), .data_out(data_out),
    .full_flag_n(full_flag_n), .input_ready_n(input_ready_n), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .almost_empty_n(almost_empty_n),
    .almost_full_n(almost_full_n), .half_full_n(half_full_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata)
  );
  dcf_link_model link (
    .thru(thru), .stall_w(stall_w), .stall_r(stall_r), .full_flag_n(full_flag_n),
    .input_ready_n(input_ready_n), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .data_out(data_out), .write_clk(write_clk),
    .read_clk(read_clk), .write_en_n(write_en_n), .read_en_n(read_en_n), .data_in(data_in)
  );
  initial
  begin
    forever #4 clk = ~clk;
  end
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic dcf_mode_t exp_mode(input logic [2:0] c);
    dcf_mode_t e;
    e.thru = (c == 3'h1) || (c == 3'h5);
    e.dbl = (c == 3'h2) || (c == 3'h6);
    e.sync_almost = (c == 3'h4) || (c == 3'h5) || (c == 3'h6);
    e.half_en = (c != 3'h3) && (c != 3'h7);
    return e;
  endfunction : exp_mode
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic reg_wr(input logic [1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : reg_rd
  task automatic do_reset(input logic [2:0] c);
    dcf_mode_t e;
    e = exp_mode(c);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= c;
    thru <= e.thru;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic put(input int k);
    repeat (k)
    begin
      seed = xs(seed);
      link.send_q.push_back(seed[DATA_W-1:0]);
      exp_q.push_back(seed[DATA_W-1:0]);
    end
  endtask : put
  // waits for k taken writes, then lets both flag sides settle
  task automatic wait_w(input int k);
    for (int i = 0; i < 6000 && link.n_wr - wbase < k; i++)
      @(posedge clk);
    repeat (80) @(posedge clk);
  endtask : wait_w
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      final_report();
    end
  end
  // ----------
  // scenarios
  // ----------
  initial
  begin
    for (int c = 0; c < 8; c++)
    begin
      do_reset(3'(c));
      reg_rd(REG_STATUS);
      chk(32'(v[9:6]), 32'(exp_mode(3'(c))));
      chk(32'(v[5:0]), 32'h32);
      // clock enable low must swallow this write
      @(posedge clk);
      ce <= 1'b0;
      reg_wr(REG_EMPTY_OFS, 16'h0005);
      ce <= 1'b1;
      reg_rd(REG_EMPTY_OFS);
      chk(32'(v), 32'(DEF_EMPTY_OFS));
      strap <= ~strap;
      repeat (6) @(posedge clk);
      reg_rd(REG_STATUS);
      chk(32'(v[9:6]), 32'(exp_mode(3'(c))));
    end
    for (int c = 0; c < 6; c++)
    begin
      md = exp_mode(3'(c));
      cap = md.thru ? DEPTH + 1 : DEPTH;
      do_reset(3'(c));
      wbase = link.n_wr;
      seed = xs(seed);
      n = 4 + seed[3:0];
      m = 4 + seed[7:4];
      reg_wr(REG_EMPTY_OFS, {7'h0, 9'(n)});
      reg_wr(REG_FULL_OFS, {7'h0, 9'(m)});
      reg_rd(REG_EMPTY_OFS);
      chk(32'(v), 32'(n));
      reg_rd(REG_FULL_OFS);
      chk(32'(v), 32'(m));
      stall_w <= 1'b0;
      put(n + md.thru);
      wait_w(n + md.thru);
      chk(32'(almost_empty_n), 32'h0);
      put(1);
      wait_w(n + md.thru + 1);
      chk(32'(almost_empty_n), 32'h1);
      put(cap - m - n - md.thru - 2);
      wait_w(cap - m - 1);
      chk(32'(almost_full_n), 32'h1);
      chk(32'(half_full_n), 32'(!md.half_en));
      put(1);
      wait_w(cap - m);
      chk(32'(almost_full_n), 32'h0);
      put(m + 4);
      wait_w(cap);
      chk(32'(link.send_q.size()), 32'h4);
      chk(32'({full_flag_n, input_ready_n}), md.thru ? 32'h3 : 32'h0);
      reg_rd(REG_LEVEL);
      chk(32'(v), 32'(cap));
      stall_r <= 1'b0;
      for (int i = 0; i < 12000 && link.got_q.size() < cap + 4; i++)
        @(posedge clk);
      repeat (80) @(posedge clk);
      chk(32'(link.got_q.size()), 32'(cap + 4));
      foreach (exp_q[i])
        chk(32'(link.got_q[i]), 32'(exp_q[i]));
      chk(32'({empty_flag_n, output_ready_n, almost_empty_n, almost_full_n, half_full_n}),
        md.thru ? 32'h1b : 32'h0b);
      stall_w <= 1'b1;
      stall_r <= 1'b1;
      exp_q.delete();
      link.got_q.delete();
    end
    final_report();
  end
endmodule : dcf_flags_tb
